// ### rtcrpm_pkg.sv
// Purpose: Constants and types of the paged RTC register map
// Assumes: One 40 MHz clock, byte access from a serial engine
// Notes:   Addresses are byte addresses, page in bits 7..3
// ============================================================
package rtcrpm_pkg;

	// Byte access from the serial engine
	typedef struct packed {
		logic       start;
		logic       wr;
		logic       rd;
		logic       stop;
		logic [7:0] data;
	} rtcrpm_acc_t;

	// ==========================================================
	// Page numbers
	localparam logic [4:0] PG_CTRL  = 5'h00;
	localparam logic [4:0] PG_WATCH = 5'h01;
	localparam logic [4:0] PG_ALARM = 5'h02;
	localparam logic [4:0] PG_TIMER = 5'h03;
	localparam logic [4:0] PG_TEMP  = 5'h04;
	localparam logic [4:0] PG_EEDAT = 5'h05;
	localparam logic [4:0] PG_EECTL = 5'h06;
	localparam logic [4:0] PG_RAM   = 5'h07;

	// ==========================================================
	// In-page counts and field positions
	localparam logic [2:0] CTRL_CNT  = 3'h5;
	localparam logic [2:0] TIME_CNT  = 3'h7;
	localparam logic [2:0] TIMER_CNT = 3'h2;
	localparam logic [2:0] EEDAT_CNT = 3'h2;
	localparam logic [2:0] EECTL_CNT = 3'h4;
	localparam int         C1_CLKINT = 7;
	localparam int         C1_TE     = 1;
	localparam int         C1_WE     = 0;
	localparam int         FL_AF     = 0;
	localparam int         FL_TF     = 1;
	localparam int         ST_PON    = 5;
	localparam int         RS_SYSR   = 4;
	localparam logic [7:0] INT_MASK  = 8'h1F;
	localparam logic [7:0] CTRL1_RST = 8'h81;

	// ==========================================================
	// Time counters: seconds, minutes, hours, days, weekdays,
	// months, years (index 0 first)
	localparam logic [6:0][7:0] TIME_MIN = {8'h00, 8'h01, 8'h01,
		8'h01, 8'h00, 8'h00, 8'h00};
	localparam logic [6:0][7:0] TIME_MAX = {8'h99, 8'h12, 8'h07,
		8'h31, 8'h23, 8'h59, 8'h59};
	localparam logic [6:0][7:0] TIME_MSK = {8'hFF, 8'h1F, 8'h07,
		8'h3F, 8'h3F, 8'h7F, 8'h7F};

	// ==========================================================
	// Prescaler taps and compensation step
	localparam int PRESC_W = 15;
	localparam int TAP_1K  = 4;
	localparam int TAP_32  = 9;
	localparam int TAP_1   = 14;
	localparam int COMP_ST = 32;
	// Calibration reset contents, arbitrary neutral values
	localparam logic [3:0][7:0] EECTL_RST = {8'h00, 8'h00,
		8'h00, 8'h00};

endpackage

// ### rtcrpm_bcd_cnt.sv
// Purpose: One BCD time counter with load and wrap
// Assumes: Limits are valid BCD
// Notes:   A load wins over an increment
`timescale 1ns/100ps
module rtcrpm_bcd_cnt #(
	parameter logic [7:0] RESET_VAL = 8'h00
) (
	// Clock and reset
	input  logic       clk,
	input  logic       rst,
	// Control
	input  logic       incr,
	input  logic       load,
	input  logic [7:0] loadVal,
	input  logic [7:0] minVal,
	input  logic [7:0] maxVal,
	// State
	output logic [7:0] value,
	output logic       carry
);
	logic [7:0] value_q;
	logic [7:0] value_d;
	logic       atMax;
	logic [7:0] nextVal;

	// BCD step with decade carry and wrap to the minimum
	assign atMax   = value_q >= maxVal;
	assign nextVal = atMax ? minVal :
		(value_q[3:0] == 4'h9) ? {value_q[7:4] + 4'h1, 4'h0} :
		{value_q[7:4], value_q[3:0] + 4'h1};
	assign value_d = load ? loadVal : (incr ? nextVal : value_q);
	assign carry   = incr & atMax & ~load;
	assign value   = value_q;

	// Counter register
	always_ff @(posedge clk) begin
		if (rst) begin
			value_q <= RESET_VAL;
		end else begin
			value_q <= value_d;
		end
	end
endmodule

// ### rtcrpm_comp.sv
// Purpose: Pulse insertion and removal on the oscillator tick
// Assumes: secTick is one cycle once per compensated second
// Notes:   Correction unit is 1/COMP_ST pulse per second
`timescale 1ns/100ps
module rtcrpm_comp #(
	parameter int ACC_W = 18
) (
	// Clock and reset
	input  logic       clk,
	input  logic       rst,
	input  logic       clr,
	// Ticks
	input  logic       oscTick,
	input  logic       secTick,
	output logic       compTick,
	// Calibration and temperature
	input  logic [7:0] offset,
	input  logic [7:0] coeff,
	input  logic [7:0] turnT,
	input  logic [7:0] temp
);
	localparam logic signed [ACC_W-1:0] STEP =
		ACC_W'(rtcrpm_pkg::COMP_ST);
	logic signed [ACC_W-1:0] acc_q;
	logic signed [ACC_W-1:0] acc_d;
	logic signed [8:0]       dt;
	logic        [16:0]      sq;
	logic        [24:0]      drift;
	logic signed [ACC_W-1:0] corr;
	logic                    addNow;
	logic                    dropNow;

	if (ACC_W < 18) begin : g_chk
		$error("ACC_W too small for the correction range");
	end

	// Parabolic drift around the turnover point, plus offset
	assign dt    = $signed({temp[7], temp}) - $signed({turnT[7], turnT});
	assign sq    = 17'($signed({{8{dt[8]}}, dt}) *
		$signed({{8{dt[8]}}, dt}));
	assign drift = {17'h00000, coeff} * {8'h00, sq};
	assign corr  = ACC_W'($signed(offset)) -
		ACC_W'($signed({1'b0, drift[24:10]}));
	// Extra pulse in a gap, or swallow a real one
	assign addNow   = (acc_q >= STEP) & ~oscTick & ~secTick;
	assign dropNow  = (acc_q <= -STEP) & oscTick & ~secTick;
	assign compTick = (oscTick & ~dropNow) | addNow;
	assign acc_d = clr ? '0 : secTick ? acc_q + corr :
		addNow ? acc_q - STEP : dropNow ? acc_q + STEP : acc_q;

	// Correction accumulator
	always_ff @(posedge clk) begin
		if (rst) begin
			acc_q <= '0;
		end else begin
			acc_q <= acc_d;
		end
	end
endmodule

// ### rtcrpm_top.sv
// Purpose: Paged register map, time counters and pin logic
// Assumes: Serial engine delivers decoded byte accesses
// Notes:   Pins oscPin and clkoePin are asynchronous
`timescale 1ns/100ps
module rtcrpm_top (
	// Clock and reset
	input  logic                     clk,
	input  logic                     rst,
	// Byte access port
	input  rtcrpm_pkg::rtcrpm_acc_t  acc,
	output logic [7:0]               rdData,
	output logic                     rdValid,
	// Thermometer result
	input  logic [7:0]               tempReading,
	// Asynchronous pins
	input  logic                     oscPin,
	input  logic                     clkoePin,
	// Shared clock output pin
	output logic                     clockOutPinO,
	output logic                     clockOutPinOeN,
	// Interrupt pin
	output logic                     intPinO,
	output logic                     intPinOeN
);
	// ==========================================================
	// Declarations
	logic [1:0]                  oscSync_q;
	logic [1:0]                  clkoeSync_q;
	logic                        oscPrev_q;
	logic [7:0]                  ptr_q;
	logic [7:0]                  ptr_d;
	logic                        freeze_q;
	logic                        pend_q;
	logic                        secTick_q;
	logic [rtcrpm_pkg::PRESC_W-1:0] presc_q;
	logic [7:0]                  ctrl1_q;
	logic [7:0]                  intEn_q;
	logic [7:0]                  flags_q;
	logic [7:0]                  flags_d;
	logic                        pon_q;
	logic [6:0][7:0]             alarm_q;
	logic [15:0]                 timer_q;
	logic [15:0]                 timer_d;
	logic [1:0][7:0]             eeData_q;
	logic [3:0][7:0]             eeCtrl_q;
	logic [7:0][7:0]             ram_q;
	logic                        alarmChk_q;
	logic [7:0]                  rdData_q;
	logic                        rdValid_q;
	logic                        clkO_q;
	logic                        clkOeN_q;
	logic                        intOeN_q;
	logic [6:0][7:0]             timeVal;
	logic [6:0]                  timeCarry;
	logic [6:0]                  timeInc;
	logic [6:0]                  timeLoad;
	logic [6:0][7:0]             timeMax;

	// ==========================================================
	// Decode
	logic [4:0] pg;
	logic [2:0] ix;
	logic       oscTick;
	logic       compTick;
	logic       clock_output_enable_pin;
	logic       pgCtrl;
	logic       pgWatch;
	logic       pgAlarm;
	logic       pgTimer;
	logic       pgTemp;
	logic       pgEeDat;
	logic       pgEeCtl;
	logic       pgRam;
	logic       wrCtrl;
	logic       sysReset;
	logic       watchTick;
	logic       tmrDec;
	logic       afSet;
	logic       tfSet;
	logic       intPend;
	logic       clkWave;
	logic [7:0] ctrlRd;
	logic [7:0] pageRd;
	logic [7:0] status;

	// Days in the current month from BCD month and year
	function automatic logic [7:0] monthDays(input logic [7:0] mon,
			input logic [7:0] yr);
		logic leap;
		leap = (yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6) :
			(yr[3:0] == 4'h0 || yr[3:0] == 4'h4 ||
			yr[3:0] == 4'h8));
		case (mon)
			8'h02:   monthDays = leap ? 8'h29 : 8'h28;
			8'h04,
			8'h06,
			8'h09,
			8'h11:   monthDays = 8'h30;
			default: monthDays = 8'h31;
		endcase
	endfunction

	// In-page index check, used by the watch, alarm, timer and EEPROM pages
	function automatic logic inPage(input logic [2:0] idx,
			input logic [2:0] cnt);
		inPage = idx < cnt;
	endfunction

	// ==========================================================
	// Pin synchronisers
	always_ff @(posedge clk) begin
		if (rst) begin
			oscSync_q   <= 2'h0;
			clkoeSync_q <= 2'h0;
			oscPrev_q   <= 1'b0;
		end else begin
			oscSync_q   <= {oscSync_q[0], oscPin};
			clkoeSync_q <= {clkoeSync_q[0], clkoePin};
			oscPrev_q   <= oscSync_q[1];
		end
	end

	assign oscTick = oscSync_q[1] & ~oscPrev_q;
	assign clock_output_enable_pin   = clkoeSync_q[1];

	// ==========================================================
	// Address pointer and page decode
	assign pg = ptr_q[7:3];
	assign ix = ptr_q[2:0];
	assign ptr_d = acc.start ? acc.data :
		(acc.wr | acc.rd) ? {ptr_q[7:3], ix + 3'h1} :
		ptr_q;
	assign pgCtrl  = pg == rtcrpm_pkg::PG_CTRL;
	assign pgWatch = pg == rtcrpm_pkg::PG_WATCH;
	assign pgAlarm = pg == rtcrpm_pkg::PG_ALARM;
	assign pgTimer = pg == rtcrpm_pkg::PG_TIMER;
	assign pgTemp  = pg == rtcrpm_pkg::PG_TEMP;
	assign pgEeDat = pg == rtcrpm_pkg::PG_EEDAT;
	assign pgEeCtl = pg == rtcrpm_pkg::PG_EECTL;
	assign pgRam   = pg == rtcrpm_pkg::PG_RAM;
	assign wrCtrl  = acc.wr & pgCtrl;

	always_ff @(posedge clk) begin
		if (rst) begin
			ptr_q <= 8'h00;
		end else begin
			ptr_q <= ptr_d;
		end
	end

	// ==========================================================
	// Freeze of the time counters during a watch read
	always_ff @(posedge clk) begin
		if (rst) begin
			freeze_q <= 1'b0;
			pend_q   <= 1'b0;
		end else begin
			if (acc.stop) begin
				freeze_q <= 1'b0;
			end else if (acc.rd & pgWatch) begin
				freeze_q <= 1'b1;
			end
			pend_q <= freeze_q & (pend_q | secTick_q);
		end
	end

	// ==========================================================
	// Compensated prescaler to one second
	assign sysReset = wrCtrl & (ix == 3'h4) &
		acc.data[rtcrpm_pkg::RS_SYSR];

	rtcrpm_comp #(
		.ACC_W(18)
	) u_comp (
		.clk     (clk),
		.rst     (rst),
		.clr     (sysReset),
		.oscTick (oscTick),
		.secTick (secTick_q),
		.compTick(compTick),
		.offset  (eeCtrl_q[1]),
		.coeff   (eeCtrl_q[2]),
		.turnT   (eeCtrl_q[3]),
		.temp    (tempReading)
	);

	always_ff @(posedge clk) begin
		if (rst | sysReset) begin
			presc_q   <= '0;
			secTick_q <= 1'b0;
		end else begin
			presc_q   <= presc_q + {14'h0, compTick};
			secTick_q <= compTick & (&presc_q);
		end
	end

	assign watchTick = ctrl1_q[rtcrpm_pkg::C1_WE] & ~freeze_q &
		(secTick_q | pend_q);

	// ==========================================================
	// Time counters
	assign timeInc  = {timeCarry[5], timeCarry[3], timeCarry[2],
		timeCarry[2], timeCarry[1], timeCarry[0], watchTick};
	assign timeMax  = {rtcrpm_pkg::TIME_MAX[6:4],
		monthDays(timeVal[5], timeVal[6]),
		rtcrpm_pkg::TIME_MAX[2:0]};

	for (genvar i = 0; i < 7; i++) begin : g_time
		assign timeLoad[i] = acc.wr & pgWatch & (ix == 3'(i));
		rtcrpm_bcd_cnt #(
			.RESET_VAL(rtcrpm_pkg::TIME_MIN[i])
		) u_cnt (
			.clk    (clk),
			.rst    (rst),
			.incr   (timeInc[i]),
			.load   (timeLoad[i]),
			.loadVal(acc.data & rtcrpm_pkg::TIME_MSK[i]),
			.minVal (rtcrpm_pkg::TIME_MIN[i]),
			.maxVal (timeMax[i]),
			.value  (timeVal[i]),
			.carry  (timeCarry[i])
		);
	end

	// ==========================================================
	// Timer, alarm match and flags
	assign tmrDec  = watchTick & ctrl1_q[rtcrpm_pkg::C1_TE] &
		(timer_q != 16'h0000);
	assign tfSet   = tmrDec & (timer_q == 16'h0001);
	assign afSet   = alarmChk_q & (timeVal[2:0] == alarm_q[2:0]);
	assign timer_d = (acc.wr & pgTimer & (ix == 3'h0)) ?
		{timer_q[15:8], acc.data} :
		(acc.wr & pgTimer & (ix == 3'h1)) ?
		{acc.data, timer_q[7:0]} :
		tmrDec ? timer_q - 16'h0001 : timer_q;
	// Writing zero clears a flag; a new event wins over the clear
	assign flags_d = (((wrCtrl & (ix == 3'h2)) ?
		(flags_q & acc.data) : flags_q) |
		{6'h0, tfSet, afSet}) & rtcrpm_pkg::INT_MASK;
	assign intPend = |(flags_q & intEn_q);

	always_ff @(posedge clk) begin
		if (rst) begin
			timer_q    <= 16'h0000;
			flags_q    <= 8'h00;
			alarmChk_q <= 1'b0;
		end else begin
			timer_q    <= timer_d;
			flags_q    <= flags_d;
			alarmChk_q <= watchTick;
		end
	end

	// ==========================================================
	// Control page registers
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl1_q <= rtcrpm_pkg::CTRL1_RST;
			intEn_q <= 8'h00;
			pon_q   <= 1'b1;
		end else begin
			if (wrCtrl & (ix == 3'h0)) begin
				ctrl1_q <= acc.data;
			end
			if (wrCtrl & (ix == 3'h1)) begin
				intEn_q <= acc.data & rtcrpm_pkg::INT_MASK;
			end
			if (wrCtrl & (ix == 3'h3) &
					~acc.data[rtcrpm_pkg::ST_PON]) begin
				pon_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Alarm, EEPROM shadow and user RAM storage
	always_ff @(posedge clk) begin
		if (rst) begin
			alarm_q  <= '0;
			eeData_q <= '0;
			eeCtrl_q <= rtcrpm_pkg::EECTL_RST;
			ram_q    <= '0;
		end else if (acc.wr) begin
			if (pgAlarm & inPage(ix, rtcrpm_pkg::TIME_CNT)) begin
				alarm_q[ix] <= acc.data &
					rtcrpm_pkg::TIME_MSK[ix];
			end
			if (pgEeDat & inPage(ix, rtcrpm_pkg::EEDAT_CNT)) begin
				eeData_q[ix[0]] <= acc.data;
			end
			if (pgEeCtl & inPage(ix, rtcrpm_pkg::EECTL_CNT)) begin
				eeCtrl_q[ix[1:0]] <= acc.data;
			end
			if (pgRam) begin
				ram_q[ix] <= acc.data;
			end
		end
	end

	// ==========================================================
	// Read selection, unused places read zero
	assign status = {2'b00, pon_q, 5'h00};
	assign ctrlRd = (ix == 3'h0) ? ctrl1_q :
		(ix == 3'h1) ? intEn_q :
		(ix == 3'h2) ? flags_q :
		(ix == 3'h3) ? status : 8'h00;
	assign pageRd =
		pgCtrl ? ctrlRd :
		(pgWatch & inPage(ix, rtcrpm_pkg::TIME_CNT)) ?
			timeVal[ix] :
		(pgAlarm & inPage(ix, rtcrpm_pkg::TIME_CNT)) ?
			alarm_q[ix] :
		(pgTimer & inPage(ix, rtcrpm_pkg::TIMER_CNT)) ?
			(ix[0] ? timer_q[15:8] : timer_q[7:0]) :
		(pgTemp & (ix == 3'h0)) ? tempReading :
		(pgEeDat & inPage(ix, rtcrpm_pkg::EEDAT_CNT)) ?
			eeData_q[ix[0]] :
		(pgEeCtl & inPage(ix, rtcrpm_pkg::EECTL_CNT)) ?
			eeCtrl_q[ix[1:0]] :
		pgRam ? ram_q[ix] : 8'h00;

	always_ff @(posedge clk) begin
		if (rst) begin
			rdData_q  <= 8'h00;
			rdValid_q <= 1'b0;
		end else begin
			rdData_q  <= acc.rd ? pageRd : rdData_q;
			rdValid_q <= acc.rd;
		end
	end

	assign rdData  = rdData_q;
	assign rdValid = rdValid_q;

	// ==========================================================
	// Pin drivers
	assign clkWave =
		(eeCtrl_q[0][1:0] == 2'h0) ? oscSync_q[1] :
		(eeCtrl_q[0][1:0] == 2'h1) ? presc_q[rtcrpm_pkg::TAP_1K] :
		(eeCtrl_q[0][1:0] == 2'h2) ? presc_q[rtcrpm_pkg::TAP_32] :
		presc_q[rtcrpm_pkg::TAP_1];

	always_ff @(posedge clk) begin
		if (rst) begin
			clkO_q   <= 1'b0;
			clkOeN_q <= 1'b1;
			intOeN_q <= 1'b1;
		end else begin
			if (ctrl1_q[rtcrpm_pkg::C1_CLKINT]) begin
				clkO_q   <= clock_output_enable_pin & clkWave;
				clkOeN_q <= 1'b0;
			end else begin
				clkO_q   <= 1'b0;
				clkOeN_q <= ~intPend;
			end
			intOeN_q <= ~intPend;
		end
	end

	assign clockOutPinO   = clkO_q;
	assign clockOutPinOeN = clkOeN_q;
	assign intPinO        = 1'b0;
	assign intPinOeN      = intOeN_q;
endmodule

// ### rtcrpm_monitor.sv
// Purpose: Port checker of the paged RTC register map
// Assumes: Clock select at 30h stays at its reset value
// Notes:   Pointer, control byte and RAM are shadowed here
`timescale 1ns/100ps
module rtcrpm_monitor (
	// Clock and reset
	input logic                    clk,
	input logic                    rst,
	// Access port
	input rtcrpm_pkg::rtcrpm_acc_t acc,
	input logic [7:0]              rdData,
	input logic                    rdValid,
	input logic [7:0]              tempReading,
	// Pins
	input logic                    oscPin,
	input logic                    clkoePin,
	input logic                    clockOutPinO,
	input logic                    clockOutPinOeN,
	input logic                    intPinO,
	input logic                    intPinOeN
);
	// ==========================================================
	// Shadow state
	localparam logic [7:0][3:0] PG_N = {4'h8, 4'h4, 4'h2, 4'h1,
		4'h2, 4'h7, 4'h7, 4'h5};
	logic [7:0] ptrQ;
	logic [7:0] ctrlQ;
	logic [7:0] ramQ [8];
	logic [1:0] sinceQ;
	logic [3:0] modeSh;
	logic [4:0] oeSh;
	logic [4:0] oscSh;
	// Decodes of the shadow pointer
	wire        ready  = (sinceQ == 2'h3);
	wire [3:0]  pgN    = (ptrQ[7:6] == 2'h0) ? PG_N[ptrQ[5:3]] : 4'h0;
	wire        unused = ({1'b0, ptrQ[2:0]} >= pgN);
	wire [7:0]  ramCur = ramQ[ptrQ[2:0]];
	wire        isRam  = (ptrQ[7:3] == rtcrpm_pkg::PG_RAM);
	wire        isTime = (ptrQ[7:3] == rtcrpm_pkg::PG_WATCH);
	// Pointer and write shadows follow the strobes
	always_ff @(posedge clk) begin
		if (rst) begin
			ptrQ   <= 8'h00;
			ctrlQ  <= rtcrpm_pkg::CTRL1_RST;
			sinceQ <= 2'h0;
			for (int i = 0; i < 8; i++) ramQ[i] <= 8'h00;
		end else begin
			if (!ready) sinceQ <= sinceQ + 2'h1;
			if (acc.wr && ptrQ == 8'h00) ctrlQ <= acc.data;
			if (acc.wr && isRam) ramQ[ptrQ[2:0]] <= acc.data;
			if (acc.start) ptrQ <= acc.data;
			else if (acc.wr || acc.rd) ptrQ[2:0] <= ptrQ[2:0] + 3'h1;
		end
	end
	// History that lets pin relations wait for settling
	always_ff @(posedge clk) begin
		modeSh <= {modeSh[2:0], ctrlQ[7]};
		oeSh   <= {oeSh[3:0], clkoePin};
		oscSh  <= {oscSh[3:0], oscPin};
	end
	// ==========================================================
	// Properties
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence rdReq;
		ready && acc.rd;
	endsequence
	sequence rdAt(hit);
		rdReq ##0 hit;
	endsequence
	rd_answer_a:
		assert property (rdReq |=> rdValid) else $error("no read answer");
	ctrl_read_a:
		assert property (rdAt(ptrQ == 8'h00) |=> rdData == $past(ctrlQ))
		else $error("control byte read wrong");
	ram_read_a:
		assert property (rdAt(isRam) |=> rdData == $past(ramCur))
		else $error("user byte read wrong");
	temp_read_a:
		assert property (rdAt(ptrQ == 8'h20) |=> rdData == $past(tempReading))
		else $error("thermometer read wrong");
	unused_zero_a:
		assert property (rdAt(unused) |=> rdData == 8'h00)
		else $error("unused place not zero");
	time_bcd_a:
		assert property (rdAt(isTime && !unused) |=>
			rdData[3:0] <= 4'h9 && rdData[7:4] <= 4'h9)
		else $error("time byte not decimal");
	clk_mode_a:
		assert property (ready && &modeSh |-> !clockOutPinOeN && !intPinO)
		else $error("clock mode not driven");
	int_mode_a:
		assert property (ready && !(|modeSh) |->
			!clockOutPinO && clockOutPinOeN == intPinOeN)
		else $error("interrupt mode not open drain");
	clk_off_a:
		assert property (ready && &modeSh && !(|oeSh) |-> !clockOutPinO)
		else $error("clock out not disabled");
	clk_on_a:
		assert property (ready && &modeSh && &oeSh && (&oscSh || !(|oscSh))
			|-> clockOutPinO == oscSh[0]) else $error("clock out stuck");
endmodule
bind rtcrpm_top rtcrpm_monitor rtcrpm_monitor_inst (
	.clk(clk), .rst(rst), .acc(acc), .rdData(rdData), .rdValid(rdValid),
	.tempReading(tempReading), .oscPin(oscPin), .clkoePin(clkoePin),
	.clockOutPinO(clockOutPinO), .clockOutPinOeN(clockOutPinOeN),
	.intPinO(intPinO), .intPinOeN(intPinOeN)
);

// ### rtcrpm_host.sv
// Purpose: Serial host stand-in issuing byte accesses
// Assumes: One strobe per clock, set 1 ns after the edge
// Notes:   Data is inverted whenever it carries no meaning
`timescale 1ns/100ps
module rtcrpm_host (
	// Clock
	input  logic                    clk,
	// Byte accesses toward the register map
	output rtcrpm_pkg::rtcrpm_acc_t acc
);
	// ==========================================================
	// Idle port at time zero
	initial begin
		acc = '0;
	end
	// Each strobe stands for exactly one taken edge
	task automatic put(input logic [3:0] kind, input logic [7:0] val);
		@(posedge clk);
		#1 acc = {kind, val};
	endtask
	// Start loads the pointer, stop ends the access
	task automatic start(input logic [7:0] addr);
		put(4'h8, addr);
	endtask
	task automatic wr(input logic [7:0] val);
		put(4'h4, val);
	endtask
	task automatic rd();
		put(4'h2, ~acc.data);
	endtask
	task automatic stop();
		put(4'h1, ~acc.data);
		put(4'h0, ~acc.data);
	endtask
endmodule

// ### rtcrpm_tb.sv
// Purpose: Self-checking bench of the paged RTC register map
// Assumes: Host leaves the calibration bytes untouched
// Notes:   Reads are noted in a queue and matched on rdValid
`timescale 1ns/100ps
module tb;
	// ==========================================================
	// Signals
	logic                    clk         = 1'b0;
	logic                    rst         = 1'b1;
	logic [7:0]              tempReading = 8'h00;
	logic                    oscPin      = 1'b0;
	logic                    clkoePin    = 1'b1;
	logic [31:0]             seed        = 32'h0000000F;
	int                      mismatches  = 0;
	int                      totalChecks = 0;
	rtcrpm_pkg::rtcrpm_acc_t acc;
	logic [7:0]              rdData;
	logic                    rdValid;
	logic                    clockOutPinO;
	logic                    clockOutPinOeN;
	logic                    intPinO;
	logic                    intPinOeN;
	logic [7:0]              vals [9];
	logic [7:0]              expQ [$];
	// Expected contents, first register first
	localparam logic [7:0] TIME_LD [7] = '{8'h59, 8'h59, 8'h23, 8'h28,
		8'h06, 8'h12, 8'h99};
	localparam logic [7:0] TIME_RS [7] = '{8'h00, 8'h00, 8'h00, 8'h01,
		8'h01, 8'h01, 8'h00};
	localparam logic [7:0] CTRL_RS [5] = '{8'h81, 8'h00, 8'h00, 8'h20,
		8'h00};
	// Design and host
	rtcrpm_top rtcrpm_top_inst (
		.clk(clk), .rst(rst), .acc(acc), .rdData(rdData), .rdValid(rdValid),
		.tempReading(tempReading), .oscPin(oscPin), .clkoePin(clkoePin),
		.clockOutPinO(clockOutPinO), .clockOutPinOeN(clockOutPinOeN),
		.intPinO(intPinO), .intPinOeN(intPinOeN)
	);
	rtcrpm_host rtcrpm_host_inst (.clk(clk), .acc(acc));
	// ==========================================================
	// Clock, slow oscillator level, watchdog
	initial begin
		forever #12.5 clk = ~clk;
	end
	initial begin
		forever begin
			repeat (8) @(posedge clk);
			#1 oscPin = ~oscPin;
		end
	end
	initial begin
		#500000;
		$display("watchdog expired");
		mismatches++;
		completeRun();
	end
	// Oldest note is matched against each read answer
	initial begin
		forever begin
			@(negedge clk);
			if (rdValid === 1'b1) begin
				if (expQ.size() == 0) check(rdData, ~rdData);
				else check(rdData, expQ.pop_front());
			end
		end
	end
	// ==========================================================
	// Helpers
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		totalChecks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic pinChk(input logic o, input logic oeN);
		check({7'h00, clockOutPinO}, {7'h00, o});
		check({7'h00, clockOutPinOeN}, {7'h00, oeN});
		check({7'h00, intPinO}, 8'h00);
		check({7'h00, intPinOeN}, 8'h01);
	endtask
	task automatic doReset();
		@(posedge clk);
		#1 rst = 1'b1;
		repeat (8) @(posedge clk);
		#1 rst = 1'b0;
	endtask
	task automatic wrVals(input logic [7:0] addr, input int n);
		rtcrpm_host_inst.start(addr);
		for (int i = 0; i < n; i++) rtcrpm_host_inst.wr(vals[i]);
		rtcrpm_host_inst.stop();
	endtask
	task automatic rdVals(input logic [7:0] addr, input int n);
		rtcrpm_host_inst.start(addr);
		for (int i = 0; i < n; i++) begin
			expQ.push_back(vals[i]);
			rtcrpm_host_inst.rd();
		end
		rtcrpm_host_inst.stop();
	endtask
	// Random bytes with one zero after them
	task automatic fillRnd(input int n);
		for (int i = 0; i < n; i++) vals[i] = rnd();
		vals[n] = 8'h00;
	endtask
	// Control page from reset, reading past the end and round
	task automatic ctrlPage();
		for (int i = 0; i < 8; i++) vals[i] = (i < 5) ? CTRL_RS[i] : 8'h00;
		vals[8] = CTRL_RS[0];
		rdVals(8'h00, 9);
		$display("test control page done");
	endtask
	task automatic completeRun();
		if (expQ.size() != 0) mismatches++;
		$display("checks %0d mismatches %0d", totalChecks, mismatches);
		if (mismatches == 0 && totalChecks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		doReset();
		ctrlPage();
		for (int i = 0; i < 7; i++) vals[i] = TIME_RS[i];
		vals[7] = 8'h00;
		rdVals(8'h08, 8);
		for (int i = 0; i < 7; i++) vals[i] = TIME_LD[i];
		wrVals(8'h08, 7);
		rdVals(8'h08, 8);
		$display("test watch page done");
		fillRnd(8);
		wrVals(8'h3F, 8);
		vals[8] = vals[0];
		for (int i = 0; i < 8; i++) vals[i] = vals[i + 1];
		vals[8] = vals[0];
		rdVals(8'h38, 9);
		$display("test user page done");
		fillRnd(2);
		wrVals(8'h18, 2);
		rdVals(8'h18, 3);
		fillRnd(2);
		wrVals(8'h28, 2);
		rdVals(8'h28, 3);
		fillRnd(7);
		wrVals(8'h10, 7);
		for (int i = 0; i < 7; i++) vals[i] &= rtcrpm_pkg::TIME_MSK[i];
		rdVals(8'h10, 8);
		for (int i = 0; i < 4; i++) vals[i] = rtcrpm_pkg::EECTL_RST[i];
		vals[4] = 8'h00;
		rdVals(8'h30, 5);
		@(posedge clk);
		#1 tempReading = rnd();
		vals[0] = ~tempReading;
		wrVals(8'h20, 1);
		vals[0] = tempReading;
		vals[1] = 8'h00;
		rdVals(8'h20, 2);
		vals[0] = 8'h00;
		rdVals(8'h47, 1);
		$display("test data pages done");
		@(posedge clk);
		#1 clkoePin = 1'b0;
		repeat (8) @(negedge clk);
		pinChk(1'b0, 1'b0);
		vals[0] = 8'h01;
		wrVals(8'h00, 1);
		repeat (8) @(negedge clk);
		pinChk(1'b0, 1'b1);
		vals[0] = 8'h81;
		wrVals(8'h00, 1);
		rdVals(8'h00, 1);
		vals[0] = 8'h00;
		vals[1] = 8'h10;
		wrVals(8'h03, 2);
		for (int i = 0; i < 5; i++) vals[i] = (i == 0) ? 8'h81 : 8'h00;
		rdVals(8'h00, 5);
		@(posedge clk);
		#1 clkoePin = 1'b1;
		repeat (40) @(posedge clk);
		$display("test pin modes done");
		doReset();
		ctrlPage();
		repeat (4) @(posedge clk);
		completeRun();
	end
endmodule
